// ==== hw/dpd_pkg.sv ====
// Function
// - Parameter bytes read F7h, A2h, D5h, 5Ch
// - Bit 31 zero: deep power-down supported
// - Enter code B9h, held in bits 30:23
// - Exit code ABh, held in bits 22:15
// - Bits 14:13 give wake delay unit
// - Delay count 00010b, host waits 3 us
// - Bits 3:2 01b, poll status 05h bit 0
// - Reserved bits 7:4 and 1:0 all ones
package dpd_pkg;
  // ****************************************
  // Instruction codes
  // ****************************************
  localparam logic [7:0] INSTR_ENTER = 8'hb9;
  localparam logic [7:0] INSTR_EXIT = 8'hab;
  localparam logic [7:0] INSTR_STATUS = 8'h05;
  localparam logic [7:0] INSTR_PARAM = 8'h5a;
  // ****************************************
  // Parameter word fields
  // ****************************************
  localparam logic [1:0] UNIT_128NS = 2'h0;
  localparam logic [1:0] UNIT_1US = 2'h1;
  localparam logic [1:0] UNIT_8US = 2'h2;
  localparam logic [4:0] DELAY_COUNT = 5'h02;
  localparam logic [1:0] POLL_LEGACY = 2'h1;
  localparam logic [3:0] RSV_HI = 4'hf;
  localparam logic [1:0] RSV_LO = 2'h3;
  localparam logic [31:0] PARAM_WORD = {1'b0, INSTR_ENTER, INSTR_EXIT, UNIT_1US,
    DELAY_COUNT, RSV_HI, POLL_LEGACY, RSV_LO};
  localparam logic [7:0] PARAM_BASE = 8'h34;
  localparam int BUSY_BIT = 0;
  // ****************************************
  // Timing at 50 MHz
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int UNIT_NS = 1000;
  localparam int WAKE_NS = (DELAY_COUNT + 1) * UNIT_NS;
  localparam int WAKE_CYC_INT = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] WAKE_CYC = 8'(WAKE_CYC_INT);
endpackage

// ==== hw/dpd_link_if.sv ====
`timescale 1ns/1ps
interface dpd_link_if;
  logic cmdValid;
  logic [7:0] cmdCode;
  logic [7:0] cmdAddr;
  logic rspValid;
  logic [7:0] rspData;
  modport flash (input cmdValid, input cmdCode, input cmdAddr, output rspValid, output rspData);
  modport host (output cmdValid, output cmdCode, output cmdAddr, input rspValid, input rspData);
endinterface

// ==== hw/dpd_flash.sv ====
`timescale 1ns/1ps
module dpd_flash
  import dpd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Link
  dpd_link_if.flash link,
  // Status
  output logic asleep,
  output logic busy
);
  logic [7:0] wakeCnt;
  logic rspValid;
  logic [7:0] rspData;
  logic accept;

  assign link.rspValid = rspValid;
  assign link.rspData = rspData;
  assign accept = link.cmdValid && !busy && !asleep;

  // ****************************************
  // Power state
  // ****************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      asleep <= 1'b0;
      busy <= 1'b0;
      wakeCnt <= 8'h00;
    end else if (asleep) begin
      if (link.cmdValid && link.cmdCode == INSTR_EXIT) begin
        asleep <= 1'b0;
        busy <= 1'b1;
        wakeCnt <= WAKE_CYC;
      end
    end else if (busy) begin
      // Busy until the advertised delay has elapsed
      if (wakeCnt <= 8'h01) begin
        busy <= 1'b0;
        wakeCnt <= 8'h00;
      end else begin
        wakeCnt <= wakeCnt - 8'h01;
      end
    end else if (accept && link.cmdCode == INSTR_ENTER) begin
      asleep <= 1'b1;
    end
  end

  // ****************************************
  // Responses
  // ****************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rspValid <= 1'b0;
      rspData <= 8'h00;
    end else begin
      rspValid <= 1'b0;
      // Status polls are served even while waking, so the host can see busy
      if (link.cmdValid && !asleep && link.cmdCode == INSTR_STATUS) begin
        rspValid <= 1'b1;
        rspData <= {7'h00, busy};
      end else if (accept && link.cmdCode == INSTR_PARAM) begin
        rspValid <= 1'b1;
        case (link.cmdAddr - PARAM_BASE)
          8'h00: rspData <= PARAM_WORD[7:0];
          8'h01: rspData <= PARAM_WORD[15:8];
          8'h02: rspData <= PARAM_WORD[23:16];
          8'h03: rspData <= PARAM_WORD[31:24];
          default: rspData <= 8'hff;
        endcase
      end
    end
  end
endmodule

// ==== hw/dpd_host.sv ====
`timescale 1ns/1ps
module dpd_host
  import dpd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // User requests, one-cycle pulses
  input wire logic reqSleep,
  input wire logic reqWake,
  // User status
  output logic sleeping,
  output logic ready,
  // Link
  dpd_link_if.host link
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ASLEEP = 5'b00010,
    ST_WAIT = 5'b00100,
    ST_POLL = 5'b01000,
    ST_RESP = 5'b10000
  } dpd_state_e;

  dpd_state_e state;
  logic [7:0] waitCnt;
  logic cmdValid;
  logic [7:0] cmdCode;

  assign link.cmdValid = cmdValid;
  assign link.cmdCode = cmdCode;
  assign link.cmdAddr = 8'h00;

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      cmdValid <= 1'b0;
      cmdCode <= 8'h00;
      waitCnt <= 8'h00;
      sleeping <= 1'b0;
      ready <= 1'b1;
    end else begin
      cmdValid <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (reqSleep) begin
            cmdValid <= 1'b1;
            cmdCode <= INSTR_ENTER;
            sleeping <= 1'b1;
            ready <= 1'b0;
            state <= ST_ASLEEP;
          end
        end
        ST_ASLEEP: begin
          if (reqWake) begin
            cmdValid <= 1'b1;
            cmdCode <= INSTR_EXIT;
            waitCnt <= WAKE_CYC;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Hold off the next operation for the wake delay
          if (waitCnt <= 8'h01) begin
            state <= ST_POLL;
          end else begin
            waitCnt <= waitCnt - 8'h01;
          end
        end
        ST_POLL: begin
          cmdValid <= 1'b1;
          cmdCode <= INSTR_STATUS;
          state <= ST_RESP;
        end
        ST_RESP: begin
          if (link.rspValid) begin
            if (link.rspData[BUSY_BIT]) begin
              state <= ST_POLL;
            end else begin
              sleeping <= 1'b0;
              ready <= 1'b1;
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

// ==== dv/dpd_link_checker.sv ====
`timescale 1ns/1ps
module dpd_link_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Link
  input wire logic cmdValid,
  input wire logic [7:0] cmdCode,
  input wire logic [7:0] cmdAddr,
  input wire logic rspValid,
  input wire logic [7:0] rspData
);
  logic [7:0] gap;
  logic dozing;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Cycles since exit; saturates so idle time never wraps
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) gap <= 8'hff;
    else if (cmdValid && cmdCode == 8'hab) gap <= 8'h01;
    else if (gap != 8'hff) gap <= gap + 8'h01;
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) dozing <= 1'b0;
    else if (cmdValid && cmdCode inside {8'hb9, 8'hab}) dozing <= cmdCode == 8'hb9;
  end
  code_legal_a: assert property (cmdValid |-> cmdCode inside {8'hb9, 8'hab, 8'h05}
    && cmdAddr == 8'h00) else $error("illegal command");
  enter_quiet_a: assert property (cmdValid && cmdCode == 8'hb9 |=> !rspValid)
    else $error("answer to enter");
  exit_quiet_a: assert property (cmdValid && cmdCode == 8'hab |=> !rspValid)
    else $error("answer to exit");
  status_answer_a: assert property (cmdValid && cmdCode == 8'h05 |=> rspValid)
    else $error("status not answered");
  answer_cause_a: assert property (rspValid |-> $past(cmdValid) && $past(cmdCode) == 8'h05)
    else $error("answer without status request");
  busy_only_a: assert property (rspValid |-> rspData[7:1] == 7'h00)
    else $error("status byte upper bits set");
  wake_gap_a: assert property (cmdValid && cmdCode == 8'h05 |-> gap >= 8'h96)
    else $error("poll before wake delay");
  sleep_quiet_a: assert property (cmdValid && dozing |-> cmdCode == 8'hab)
    else $error("command while asleep");
endmodule

// ==== dv/tb_deep_power_down_param_readback.sv ====
`timescale 1ns/1ps
module tb_deep_power_down_param_readback;
  import dpd_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic reqSleep = 1'b0;
  logic reqWake = 1'b0;
  logic sleeping, ready, asleep, busy;
  logic [7:0] word [4] = '{8'hf7, 8'ha2, 8'hd5, 8'h5c};
  int bad_count = 0;
  int total_checks = 0;
  int i;
  dpd_link_if link();
  dpd_link_if probe();
  dpd_host i_dpd_host (.core_clk(core_clk), .arst_n(arst_n), .reqSleep(reqSleep),
    .reqWake(reqWake), .sleeping(sleeping), .ready(ready), .link(link));
  dpd_flash i_dpd_flash (.core_clk(core_clk), .arst_n(arst_n), .link(link),
    .asleep(asleep), .busy(busy));
  // Second end driven directly to reach reads and refusals the host never issues
  dpd_flash i_dpd_flash_probe (.core_clk(core_clk), .arst_n(arst_n), .link(probe),
    .asleep(), .busy());
  dpd_link_checker i_dpd_link_checker (.core_clk(core_clk), .arst_n(arst_n),
    .cmdValid(link.cmdValid), .cmdCode(link.cmdCode), .cmdAddr(link.cmdAddr),
    .rspValid(link.rspValid), .rspData(link.rspData));
  initial forever #10 core_clk = ~core_clk;
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Expected: bit 8 answered, bits 7:0 byte
  task send(input logic [7:0] code, input logic [7:0] addr, input logic [8:0] exp);
    probe.cmdValid <= 1'b1;
    probe.cmdCode <= code;
    probe.cmdAddr <= addr;
    @(posedge core_clk);
    probe.cmdValid <= 1'b0;
    #1;
    chk({7'h00, probe.rspValid}, {7'h00, exp[8]});
    if (exp[8]) chk(probe.rspData, exp[7:0]);
    @(posedge core_clk);
  endtask
  task close_out;
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    probe.cmdValid = 1'b0;
    probe.cmdCode = 8'h00;
    probe.cmdAddr = 8'h00;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    for (i = 0; i < 4; i++) send(INSTR_PARAM, 8'h34 + 8'(i), {1'b1, word[i]});
    send(INSTR_PARAM, 8'h38, 9'h1ff);
    send(INSTR_ENTER, 8'h00, 9'h000);
    send(INSTR_STATUS, 8'h00, 9'h000);
    send(INSTR_PARAM, 8'h34, 9'h000);
    send(INSTR_EXIT, 8'h00, 9'h000);
    send(INSTR_STATUS, 8'h00, 9'h101);
    send(INSTR_PARAM, 8'h34, 9'h000);
    send(INSTR_ENTER, 8'h00, 9'h000);
    repeat (150) @(posedge core_clk);
    send(INSTR_STATUS, 8'h00, 9'h100);
    reqSleep <= 1'b1;
    @(posedge core_clk);
    reqSleep <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({6'h00, sleeping, ready}, 8'h02);
    chk({7'h00, asleep}, 8'h01);
    reqWake <= 1'b1;
    @(posedge core_clk);
    reqWake <= 1'b0;
    // Sample after the edge so a same-edge update is never missed
    for (i = 0; i < 400 && ready !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (i >= 400) bad_count++;
    chk({7'h00, 1'(i >= 150)}, 8'h01);
    chk({6'h00, sleeping, ready}, 8'h01);
    chk({6'h00, asleep, busy}, 8'h00);
    close_out();
  end
endmodule
